// [hdl/cam_pkg.sv]
// Shared constants for the quadrature electronic cam
package cam_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int          POS_WIDTH      = 24;
  localparam int          NUM_LOBES      = 8;
  localparam int          CLK_FREQ_HZ    = 40_000_000;
  localparam int          TICK_PERIOD_NS = 1000;
  localparam int          TICK_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * TICK_PERIOD_NS / 1000;
  localparam logic [5:0]  TICK_LAST      = 6'(TICK_CYCLES - 1);
  localparam logic [3:0]  DECADE_LAST    = 4'h9;
  localparam int          DECADE_STAGES  = 3;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_CFG_STORED = 8'h04;
  localparam logic [7:0]  OFS_CFG_OVR    = 8'h08;
  localparam logic [7:0]  OFS_COUNTS_REV = 8'h0c;
  localparam logic [7:0]  OFS_POSITION   = 8'h10;
  localparam logic [7:0]  OFS_OUTPUTS    = 8'h14;
  localparam logic [7:0]  OFS_LOBE_BASE  = 8'h20;
  localparam logic [7:0]  OFS_LOBE_END   = 8'h5c;

  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int          CTRL_OVERRIDE_MASK = 0;
  localparam int          CTRL_ASYNC_RESET   = 1;
  localparam int          CTRL_ENABLE        = 2;
  localparam logic [31:0] CTRL_USED          = 32'h0000_0007;
  localparam logic [31:0] CTRL_RESET         = 32'h0000_0004;

  // ----------------------------------------
  // Configuration word fields
  // ----------------------------------------
  localparam int          CFG_MERGE_LSB      = 0;
  localparam int          CFG_MARKER_LOW     = 8;
  localparam int          CFG_MARKER_PHASE   = 9;
  localparam int          CFG_CLK_SEL_LSB    = 10;
  localparam int          CFG_USE_INTERNAL   = 12;
  localparam int          CFG_NEGATE_LSB     = 16;
  localparam logic [31:0] CFG_USED           = 32'h00ff_1f7f;
  localparam logic [31:0] CFG_RESET          = 32'h0000_0000;
  localparam logic [31:0] COUNTS_REV_RESET   = 32'h0000_0000;
  localparam logic [31:0] SETPOINT_RESET     = 32'h0000_0000;

  // Transfer size of a whole word
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;

endpackage

// [hdl/cam_quad_decoder.sv]
// Encoder input conditioning, 4X quadrature decode and marker detection
`timescale 1ns/1ps
module cam_quad_decoder
  import cam_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic enc_a,
  input  wire logic enc_b,
  input  wire logic enc_marker,
  input  wire logic marker_disable,
  input  wire logic marker_active_low,
  input  wire logic marker_phase_high,
  output logic      step_up,
  output logic      step_down,
  output logic      marker_hit
);

  // ----------------------------------------
  // Pin synchronisers and agreement filter
  // ----------------------------------------
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  logic [3:0] level;
  logic [3:0] level_prev;
  logic [3:0] next_level;
  logic       marker_q;
  logic       marker_prev;
  logic       a_edge;
  logic       b_edge;

  always_comb begin
    // A level only moves once the second and third stages agree
    next_level = (sync2 & ~(sync2 ^ sync3)) | (level & (sync2 ^ sync3));
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1       <= 4'h0;
      sync2       <= 4'h0;
      sync3       <= 4'h0;
      level       <= 4'h0;
      level_prev  <= 4'h0;
      marker_prev <= 1'b0;
    end else begin
      sync1       <= {marker_disable, enc_marker, enc_b, enc_a};
      sync2       <= sync1;
      sync3       <= sync2;
      level       <= next_level;
      level_prev  <= level;
      marker_prev <= marker_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    a_edge = level[0] ^ level_prev[0];
    b_edge = level[1] ^ level_prev[1];
    // Both phases moving at once is an illegal transition and is dropped
    step_up   = (a_edge & ~b_edge & (level[0] ^ level[1]))
              | (b_edge & ~a_edge & ~(level[0] ^ level[1]));
    step_down = (a_edge & ~b_edge & ~(level[0] ^ level[1]))
              | (b_edge & ~a_edge & (level[0] ^ level[1]));
    marker_q  = (level[2] ^ marker_active_low)
              & (level[1] == marker_phase_high)
              & ~level[3];
    marker_hit = marker_q & ~marker_prev;
  end

endmodule

// [hdl/cam_timebase.sv]
// Internal count clock: 1 us base tick and decade prescaler
`timescale 1ns/1ps
module cam_timebase
  import cam_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [1:0] clk_sel,
  output logic            tick
);

  // ----------------------------------------
  // Base divider
  // ----------------------------------------
  logic [5:0] base_cnt;
  logic [5:0] next_base_cnt;
  logic [DECADE_STAGES:0] stage_tick;

  always_comb begin
    next_base_cnt = (base_cnt == TICK_LAST) ? 6'h00 : base_cnt + 6'h01;
    stage_tick[0] = (base_cnt == TICK_LAST);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      base_cnt <= 6'h00;
    end else begin
      base_cnt <= next_base_cnt;
    end
  end

  // ----------------------------------------
  // Decade stages: 100 kHz, 10 kHz, 1 kHz
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < DECADE_STAGES; g++) begin : gen_decade
      logic [3:0] dec_cnt;
      logic [3:0] next_dec_cnt;
      always_comb begin
        next_dec_cnt = dec_cnt;
        if (stage_tick[g]) begin
          next_dec_cnt = (dec_cnt == DECADE_LAST) ? 4'h0 : dec_cnt + 4'h1;
        end
        stage_tick[g+1] = stage_tick[g] & (dec_cnt == DECADE_LAST);
      end
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          dec_cnt <= 4'h0;
        end else begin
          dec_cnt <= next_dec_cnt;
        end
      end
    end
  endgenerate

  always_comb begin
    tick = stage_tick[clk_sel];
  end

endmodule

// [hdl/quadrature_electronic_cam.sv]
// Electronic cam top: AHB-Lite registers, position counter, lobes and merges
`timescale 1ns/1ps
module quadrature_electronic_cam
  import cam_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        enc_a,
  input  wire logic        enc_b,
  input  wire logic        enc_marker,
  input  wire logic        marker_disable,
  output logic [7:0]       cam_out
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [31:0]          ctrl;
  logic [31:0]          cfg_stored;
  logic [31:0]          cfg_ovr;
  logic [31:0]          counts_rev;
  logic [31:0]          set_low  [NUM_LOBES];
  logic [31:0]          set_high [NUM_LOBES];
  logic [31:0]          next_ctrl;
  logic [31:0]          next_cfg_stored;
  logic [31:0]          next_cfg_ovr;
  logic [31:0]          next_counts_rev;
  logic [31:0]          next_set_low  [NUM_LOBES];
  logic [31:0]          next_set_high [NUM_LOBES];
  logic                 wr_pending;
  logic [7:0]           wr_addr;
  logic                 next_wr_pending;
  logic [7:0]           next_wr_addr;
  logic [31:0]          next_hrdata;
  logic                 addr_phase;
  logic [31:0]          cfg;
  logic [POS_WIDTH-1:0] count;
  logic [POS_WIDTH-1:0] next_count;
  logic [POS_WIDTH-1:0] last_count;
  logic                 counter_clear;
  logic                 enc_up;
  logic                 enc_down;
  logic                 enc_marker_hit;
  logic                 int_tick;
  logic                 cnt_up;
  logic                 cnt_down;
  logic                 cnt_zero;
  logic [NUM_LOBES-1:0] lobe_on;
  logic [6:0]           merge;
  logic [7:0]           next_cam_out;
  logic                 ch2;
  logic                 ch4;
  logic                 ch6;

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  // Zero wait states: every transfer completes in its first data phase
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    addr_phase      = hsel & hready & htrans[1];
    next_wr_pending = addr_phase & hwrite & (hsize == HSIZE_WORD);
    next_wr_addr    = (addr_phase & hwrite) ? {haddr[7:2], 2'b00} : wr_addr;
    next_hrdata     = hrdata;
    if (addr_phase & ~hwrite) begin
      next_hrdata = read_word({haddr[7:2], 2'b00});
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pending <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata     <= 32'h0000_0000;
    end else begin
      wr_pending <= next_wr_pending;
      wr_addr    <= next_wr_addr;
      hrdata     <= next_hrdata;
    end
  end

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [2:0] idx;
    idx = a[5:3] - 3'h4;
    read_word = 32'h0000_0000;
    case (a)
      OFS_CTRL:       read_word = ctrl;
      OFS_CFG_STORED: read_word = cfg_stored;
      OFS_CFG_OVR:    read_word = cfg_ovr;
      OFS_COUNTS_REV: read_word = counts_rev;
      OFS_POSITION:   read_word = {8'h00, count};
      OFS_OUTPUTS:    read_word = {24'h00_0000, cam_out};
      default: begin
        if (a >= OFS_LOBE_BASE && a <= OFS_LOBE_END) begin
          read_word = a[2] ? set_high[idx] : set_low[idx];
        end
      end
    endcase
  endfunction

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  always_comb begin
    next_ctrl       = ctrl;
    next_cfg_stored = cfg_stored;
    next_cfg_ovr    = cfg_ovr;
    next_counts_rev = counts_rev;
    for (int i = 0; i < NUM_LOBES; i++) begin
      next_set_low[i]  = set_low[i];
      next_set_high[i] = set_high[i];
    end
    if (wr_pending) begin
      case (wr_addr)
        OFS_CTRL:       next_ctrl       = hwdata & CTRL_USED;
        OFS_CFG_STORED: next_cfg_stored = hwdata & CFG_USED;
        OFS_CFG_OVR:    next_cfg_ovr    = hwdata & CFG_USED;
        OFS_COUNTS_REV: next_counts_rev = hwdata;
        default: begin
          if (wr_addr >= OFS_LOBE_BASE && wr_addr <= OFS_LOBE_END) begin
            if (wr_addr[2]) begin
              next_set_high[3'(wr_addr[5:3] - 3'h4)] = hwdata;
            end else begin
              next_set_low[3'(wr_addr[5:3] - 3'h4)]  = hwdata;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl       <= CTRL_RESET;
      cfg_stored <= CFG_RESET;
      cfg_ovr    <= CFG_RESET;
      counts_rev <= COUNTS_REV_RESET;
      for (int i = 0; i < NUM_LOBES; i++) begin
        set_low[i]  <= SETPOINT_RESET;
        set_high[i] <= SETPOINT_RESET;
      end
    end else begin
      ctrl       <= next_ctrl;
      cfg_stored <= next_cfg_stored;
      cfg_ovr    <= next_cfg_ovr;
      counts_rev <= next_counts_rev;
      for (int i = 0; i < NUM_LOBES; i++) begin
        set_low[i]  <= next_set_low[i];
        set_high[i] <= next_set_high[i];
      end
    end
  end

  // ----------------------------------------
  // Active configuration
  // ----------------------------------------
  always_comb begin
    cfg   = ctrl[CTRL_OVERRIDE_MASK] ? cfg_ovr : cfg_stored;
    merge = cfg[CFG_MERGE_LSB +: 7];
    // Zero or 2^24 both give a full 24-bit revolution
    last_count = POS_WIDTH'(counts_rev - 32'h0000_0001);
  end

  // ----------------------------------------
  // Count sources
  // ----------------------------------------
  cam_quad_decoder u_decoder (
    .clk               (clk),
    .sys_rst           (sys_rst),
    .enc_a             (enc_a),
    .enc_b             (enc_b),
    .enc_marker        (enc_marker),
    .marker_disable    (marker_disable),
    .marker_active_low (cfg[CFG_MARKER_LOW]),
    .marker_phase_high (cfg[CFG_MARKER_PHASE]),
    .step_up           (enc_up),
    .step_down         (enc_down),
    .marker_hit        (enc_marker_hit)
  );

  cam_timebase u_timebase (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clk_sel (cfg[CFG_CLK_SEL_LSB +: 2]),
    .tick    (int_tick)
  );

  // ----------------------------------------
  // Position counter
  // ----------------------------------------
  // Cleared without the clock so the host bit acts even if the source stalls
  assign counter_clear = sys_rst | ctrl[CTRL_ASYNC_RESET];

  always_comb begin
    // Clearing the enable bit halts the cam; setting the counter reset bit also holds it at zero
    cnt_up   = ctrl[CTRL_ENABLE] & (cfg[CFG_USE_INTERNAL] ? int_tick : enc_up);
    cnt_down = ctrl[CTRL_ENABLE] & ~cfg[CFG_USE_INTERNAL] & enc_down;
    cnt_zero = ctrl[CTRL_ENABLE] & ~cfg[CFG_USE_INTERNAL] & enc_marker_hit;
    next_count = count;
    if (cnt_zero) begin
      next_count = '0;
    end else if (cnt_up) begin
      next_count = (count >= last_count) ? '0 : count + 1'b1;
    end else if (cnt_down) begin
      next_count = (count == '0) ? last_count : count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge counter_clear) begin
    if (counter_clear) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // ----------------------------------------
  // Lobe comparators
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_LOBES; g++) begin : gen_lobe
      logic [31:0] eff_high;
      logic        in_range;
      always_comb begin
        eff_high = (set_high[g] > {8'h00, last_count}) ? {8'h00, last_count}
                                                       : set_high[g];
        in_range = ({8'h00, count} >= set_low[g])
                 & ({8'h00, count} <= eff_high)
                 & (set_low[g] <= {8'h00, last_count});
        lobe_on[g] = in_range ^ cfg[CFG_NEGATE_LSB + g];
      end
    end
  endgenerate

  // ----------------------------------------
  // Merge network and output register
  // ----------------------------------------
  always_comb begin
    // Merges chain through intermediate channels so all seven others can reach 8
    ch2 = lobe_on[1] | (merge[0] & lobe_on[0]);
    ch4 = lobe_on[3] | (merge[1] & ch2) | (merge[2] & lobe_on[2]);
    ch6 = lobe_on[5] | (merge[4] & lobe_on[4]);
    next_cam_out[0] = ~merge[0] & lobe_on[0];
    next_cam_out[1] = ~merge[1] & ch2;
    next_cam_out[2] = ~merge[2] & lobe_on[2];
    next_cam_out[3] = ~merge[3] & ch4;
    next_cam_out[4] = ~merge[4] & lobe_on[4];
    next_cam_out[5] = ~merge[5] & ch6;
    next_cam_out[6] = ~merge[6] & lobe_on[6];
    next_cam_out[7] = lobe_on[7] | (merge[3] & ch4) | (merge[5] & ch6)
                    | (merge[6] & lobe_on[6]);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cam_out <= 8'h00;
    end else begin
      cam_out <= next_cam_out;
    end
  end

endmodule

// [verif/cam_checker_assertions.sv]
// Checker: bus, readback and cam output properties seen at the cam's ports
`timescale 1ns/1ps
module cam_checker
  import cam_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        enc_a,
  input wire logic        enc_b,
  input wire logic        enc_marker,
  input wire logic        marker_disable,
  input wire logic [7:0]  cam_out
);
  // ----------------------------------------
  // Configuration shadow rebuilt from bus writes
  // ----------------------------------------
  logic        wr_p;
  logic [7:0]  wr_a;
  logic [31:0] ctl;
  logic [31:0] cfs;
  logic [31:0] cfo;
  logic [31:0] act;
  logic [2:0]  wr_age;
  logic [3:0]  pin_age;
  logic [3:0]  pins_q;
  logic [3:0]  pins;

  assign pins = {enc_a, enc_b, enc_marker, marker_disable};
  assign act  = ctl[CTRL_OVERRIDE_MASK] ? cfo : cfs;

  // Ages saturate so that quiet periods can be recognised without a long count
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_p    <= 1'b0;
      wr_a    <= 8'h00;
      ctl     <= CTRL_RESET;
      cfs     <= CFG_RESET;
      cfo     <= CFG_RESET;
      wr_age  <= 3'h0;
      pin_age <= 4'h0;
      pins_q  <= 4'h0;
    end else begin
      wr_p    <= hsel && hready && htrans[1] && hwrite && hsize == HSIZE_WORD;
      wr_a    <= haddr[7:0];
      if (wr_p && wr_a == OFS_CTRL) ctl <= hwdata & CTRL_USED;
      if (wr_p && wr_a == OFS_CFG_STORED) cfs <= hwdata & CFG_USED;
      if (wr_p && wr_a == OFS_CFG_OVR) cfo <= hwdata & CFG_USED;
      wr_age  <= wr_p ? 3'h0 : wr_age + {2'h0, wr_age != 3'h7};
      pin_age <= (pins != pins_q) ? 4'h0 : pin_age + {3'h0, pin_age != 4'hf};
      pins_q  <= pins;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
  endsequence

  AST_READY_OKAY: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with an error");
  AST_POS_WIDTH: assert property (s_rd(OFS_POSITION) |=> hrdata[31:24] == 8'h00)
    else $error("position read wider than 24 bits");
  AST_ARST_POS: assert property (
    s_rd(OFS_POSITION) ##0 ctl[CTRL_ASYNC_RESET] |=> hrdata == 32'h0)
    else $error("position not held at zero by the counter reset bit");
  AST_OUT_READ: assert property (
    s_rd(OFS_OUTPUTS) |=> hrdata == {24'h0, $past(cam_out)})
    else $error("output readback differs from the channel pins");
  AST_UNMAPPED: assert property (s_rd(8'h18) |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_CFG_READ: assert property (s_rd(OFS_CFG_STORED) |=> hrdata == $past(cfs))
    else $error("stored configuration readback wrong");
  AST_MERGE_AWAY: assert property (
    wr_age == 3'h7 |-> (cam_out & {1'b0, act[6:0]}) == 8'h00)
    else $error("merged-away channel driven");
  AST_STABLE: assert property (
    pin_age == 4'hf && wr_age == 3'h7 && !act[CFG_USE_INTERNAL] |=> $stable(cam_out))
    else $error("channels moved without an encoder edge");
endmodule

// [verif/enc_model.sv]
// Model: rotary quadrature encoder with marker output
`timescale 1ns/1ps
module enc_model (
  input  wire logic clk,
  output logic      enc_a,
  output logic      enc_b,
  output logic      enc_marker
);
  logic [1:0] st;

  initial begin
    st = 2'h0;
    enc_a = 1'b0;
    enc_b = 1'b0;
    enc_marker = 1'b0;
  end

  // Gray sequence, one phase edge per step; 8 clk spacing clears the pin filter
  task automatic step(input logic up);
    repeat (8) @(posedge clk);
    st = up ? st + 2'h1 : st - 2'h1;
    enc_a <= st[1] ^ st[0];
    enc_b <= st[1];
  endtask

  // Marker moves only while both phases rest, so no phase edge coincides with a marker edge
  task automatic mark(input logic v);
    repeat (8) @(posedge clk);
    enc_marker <= v;
  endtask
endmodule

// [verif/quadrature_electronic_cam_tb.sv]
// Testbench: registers, encoder counting, marker, merges and timebase of the cam
`timescale 1ns/1ps
module quadrature_electronic_cam_tb
  import cam_pkg::*;
;
  logic        clk = 1'b0;
  logic        sys_rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        enc_a;
  logic        enc_b;
  logic        enc_marker;
  logic        marker_disable;
  logic [7:0]  cam_out;
  logic [31:0] rd;
  logic [7:0]  mg = 8'h00;
  logic [7:0]  neg = 8'h00;
  int          lo[8];
  int          hi[8];
  int          last = 16777215;
  int          pos = 0;
  int          failures = 0;
  int          num_checks = 0;

  assign hready = hreadyout;
  always #12.5 clk = ~clk;

  quadrature_electronic_cam quadrature_electronic_cam_inst (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .enc_a(enc_a), .enc_b(enc_b), .enc_marker(enc_marker), .marker_disable(marker_disable),
    .cam_out(cam_out));
  enc_model enc_model_inst (.clk(clk), .enc_a(enc_a), .enc_b(enc_b), .enc_marker(enc_marker));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_cam(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Merge bit j moves channel j; the walk order lets chains reach channel 8
  function automatic logic [7:0] exp_cam(input int p);
    logic [7:0] a;
    int         s[7] = '{0, 4, 6, 1, 2, 5, 3};
    int         d[7] = '{1, 5, 7, 3, 3, 7, 7};
    for (int k = 0; k < 8; k++) begin
      a[k] = (lo[k] <= p && p <= hi[k] && lo[k] <= last) ^ neg[k];
    end
    for (int j = 0; j < 7; j++) begin
      if (mg[s[j]]) begin
        a[d[j]] = a[d[j]] | a[s[j]];
        a[s[j]] = 1'b0;
      end
    end
    return a;
  endfunction

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic settle();
    repeat (12) @(posedge clk);
    bus(1'b0, OFS_POSITION, 32'h0);
    chk_word(rd, 32'(pos));
    chk_cam(cam_out, exp_cam(pos));
  endtask

  task automatic move(input logic up, input int n);
    repeat (n) begin
      enc_model_inst.step(up);
      pos = up ? (pos == last ? 0 : pos + 1) : (pos == 0 ? last : pos - 1);
      settle();
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    // A byte-sized write must leave the control word untouched
    hsize <= 3'h0;
    bus(1'b1, OFS_CTRL, 32'h0);
    hsize <= HSIZE_WORD;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk_word(rd, CTRL_RESET);
    bus(1'b0, OFS_COUNTS_REV, 32'h0);
    chk_word(rd, COUNTS_REV_RESET);
    bus(1'b0, 8'h18, 32'h0);
    chk_word(rd, 32'h0);
    bus(1'b1, OFS_POSITION, 32'h55);
    settle();
    move(1'b0, 1);
    move(1'b1, 1);
    $display("reset test done");
  endtask

  task automatic t_count();
    for (int k = 0; k < 8; k++) begin
      lo[k] = 2 * k;
      hi[k] = (k == 6) ? 100 : 2 * k + 1;
    end
    lo[7] = 20;
    hi[7] = 30;
    last = 15;
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, OFS_LOBE_BASE + 8'(8 * k), 32'(lo[k]));
      bus(1'b1, OFS_LOBE_BASE + 8'(8 * k + 4), 32'(hi[k]));
    end
    bus(1'b1, OFS_COUNTS_REV, 32'h10);
    settle();
    move(1'b1, 17);
    move(1'b0, 3);
    $display("count test done");
  endtask

  task automatic t_marker();
    enc_model_inst.mark(1'b1);
    enc_model_inst.mark(1'b0);
    settle();
    move(1'b1, 3);
    marker_disable <= 1'b1;
    enc_model_inst.mark(1'b1);
    enc_model_inst.mark(1'b0);
    settle();
    marker_disable <= 1'b0;
    enc_model_inst.mark(1'b1);
    enc_model_inst.mark(1'b0);
    pos = 0;
    settle();
    move(1'b1, 1);
    bus(1'b1, OFS_CFG_STORED, 32'h200);
    enc_model_inst.mark(1'b1);
    enc_model_inst.mark(1'b0);
    pos = 0;
    settle();
    bus(1'b1, OFS_CFG_STORED, 32'h300);
    bus(1'b0, OFS_CFG_STORED, 32'h0);
    chk_word(rd, 32'h300);
    enc_model_inst.mark(1'b1);
    move(1'b1, 4);
    enc_model_inst.mark(1'b0);
    enc_model_inst.mark(1'b1);
    pos = 0;
    settle();
    bus(1'b1, OFS_CFG_STORED, 32'h0);
    enc_model_inst.mark(1'b0);
    $display("marker test done");
  endtask

  task automatic t_merge();
    bus(1'b1, OFS_CFG_OVR, 32'h00ff_007f);
    settle();
    bus(1'b1, OFS_CTRL, 32'h5);
    mg = 8'h7f;
    neg = 8'hff;
    settle();
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, OFS_CFG_OVR, 32'h00ff_0000 | (32'h1 << i));
      mg = 8'h1 << i;
      settle();
    end
    bus(1'b1, OFS_CTRL, CTRL_RESET);
    mg = 8'h00;
    neg = 8'h00;
    settle();
    $display("merge test done");
  endtask

  // Reads are gap clk apart, 400 or 4000, so a whole number of ticks falls between them
  task automatic t_timer(input logic [31:0] cfg, input logic [31:0] ctl, input int gap,
                         input int adv);
    bus(1'b1, OFS_CTRL, ctl);
    bus(1'b1, OFS_CFG_STORED, cfg);
    bus(1'b0, OFS_POSITION, 32'h0);
    pos = int'(rd[23:0]);
    repeat (gap - 3) @(posedge clk);
    bus(1'b0, OFS_POSITION, 32'h0);
    chk_word(rd, 32'((pos + adv) % 16));
    $display("timer test done");
  endtask

  task automatic t_arst();
    bus(1'b1, OFS_CFG_STORED, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h6);
    bus(1'b0, OFS_POSITION, 32'h0);
    chk_word(rd, 32'h0);
    bus(1'b1, OFS_CTRL, CTRL_RESET);
    pos = 0;
    move(1'b1, 2);
    $display("counter reset test done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    sys_rst <= 1'b1;
    hsel <= 1'b0;
    haddr <= 32'h0;
    htrans <= 2'h0;
    hwrite <= 1'b0;
    hsize <= HSIZE_WORD;
    hwdata <= 32'h0;
    marker_disable <= 1'b0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_count();
    t_marker();
    t_merge();
    t_timer(32'h1000, CTRL_RESET, 400, 10);
    t_timer(32'h1400, CTRL_RESET, 4000, 10);
    t_timer(32'h1000, 32'h0, 400, 0);
    t_arst();
    print_verdict();
  end

  // The run needs about 6k clk; the margin covers a slow decoder
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    print_verdict();
  end
endmodule

bind quadrature_electronic_cam cam_checker cam_checker_inst (.clk(clk), .sys_rst(sys_rst),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .enc_a(enc_a), .enc_b(enc_b), .enc_marker(enc_marker), .marker_disable(marker_disable),
  .cam_out(cam_out));
